// >>> core/dioca_channel.sv
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "dioca_params.svh"
module dioca_channel #(
  parameter int STEP_CYC = `DIOCA_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic line_in,
  input wire logic failsafe_expired,
  output logic drive_high,
  output logic drive_low,
  output logic event_valid,
  output logic event_alarm_set,
  output logic event_email,
  output logic event_log,
  output logic event_trap,
  output logic [2:0] event_severity,
  output logic event_value
);
  import dioca_pkg::*;

  // ----------------------------------------
  // configuration and state registers
  // ----------------------------------------
  logic [9:0] ctrl_reg;
  logic [6:0] outcfg_reg;
  logic [13:0] actw_reg;
  logic [13:0] inactw_reg;
  logic [13:0] delay_reg;
  logic [13:0] pcount_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic ack_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic level_reg;
  logic latched_reg;
  logic out_active_reg;
  dioca_alarm_t alarm_reg;
  dioca_ost_t ost_reg;
  logic [31:0] tick_reg;
  logic [13:0] units_reg;
  logic [13:0] pulses_reg;

  // the access edge is the one where waitrequest is already low
  wire wr_acc = avs_write && ack_reg;
  wire rd_acc = avs_read && ack_reg;
  wire out_mode = ctrl_reg[`DIOCA_CTRL_OUTMODE];
  wire dioca_latch_t latch_sel =
    dioca_latch_t'(ctrl_reg[`DIOCA_CTRL_LATCH_LO +: 2]);
  wire dioca_trig_t trig_sel =
    dioca_trig_t'(ctrl_reg[`DIOCA_CTRL_TRIG_LO +: 2]);
  wire dioca_drv_t drv_sel =
    dioca_drv_t'(outcfg_reg[`DIOCA_OUT_TYPE_LO +: 2]);
  wire dioca_omode_t om_sel =
    dioca_omode_t'(outcfg_reg[`DIOCA_OUT_MODE_LO +: 2]);
  wire dioca_fs_t fs_sel =
    dioca_fs_t'(outcfg_reg[`DIOCA_OUT_FS_LO +: 2]);

  // write strobe for one register, low byte lane must be enabled
  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_acc && (avs_address == ofs) && avs_byteenable[0];
  endfunction : hit

  // clamp a programmed width into 1..9999 units
  function automatic logic [13:0] clampu(input logic [31:0] d);
    if (d[13:0] < `DIOCA_UNITS_MIN)
      clampu = `DIOCA_UNITS_MIN;
    else if (d[13:0] > `DIOCA_UNITS_MAX || d[31:14] != 18'h0_0000)
      clampu = `DIOCA_UNITS_MAX;
    else
      clampu = d[13:0];
  endfunction : clampu

  // ----------------------------------------
  // bus handshake: one wait cycle, then ack
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read || avs_write) && !ack_reg;
  end
  // waitrequest is its own flop, always the inverse of ack_reg, so the
  // pin sees no gate after the register
  always_ff @(posedge clk) begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `DIOCA_CTRL_RESET;
      outcfg_reg <= `DIOCA_OUTCFG_RESET;
      actw_reg <= `DIOCA_UNITS_RESET;
      inactw_reg <= `DIOCA_UNITS_RESET;
      delay_reg <= `DIOCA_UNITS_RESET;
      pcount_reg <= `DIOCA_UNITS_RESET;
      irq_mask_reg <= 4'h0;
    end else begin
      if (hit(`DIOCA_OFS_CTRL) && ack_reg)
        ctrl_reg <= avs_writedata[9:0];
      if (hit(`DIOCA_OFS_OUTCFG) && ack_reg)
        outcfg_reg <= avs_writedata[6:0];
      if (hit(`DIOCA_OFS_ACTW) && ack_reg)
        actw_reg <= clampu(avs_writedata);
      if (hit(`DIOCA_OFS_INACTW) && ack_reg)
        inactw_reg <= clampu(avs_writedata);
      if (hit(`DIOCA_OFS_DELAY) && ack_reg)
        delay_reg <= clampu(avs_writedata);
      if (hit(`DIOCA_OFS_PCOUNT) && ack_reg)
        pcount_reg <= clampu(avs_writedata);
      if (hit(`DIOCA_OFS_IRQ_MASK) && ack_reg)
        irq_mask_reg <= avs_writedata[3:0];
    end
  end

  wire cmd_wr = hit(`DIOCA_OFS_CMD) && ack_reg;
  wire cmd_on = cmd_wr && avs_writedata[`DIOCA_CMD_ON];
  wire cmd_off = cmd_wr && avs_writedata[`DIOCA_CMD_OFF];
  wire cmd_clear = cmd_wr && avs_writedata[`DIOCA_CMD_CLEAR];
  wire fs_hit = failsafe_expired ||
    (cmd_wr && avs_writedata[`DIOCA_CMD_FAILSAFE]);

  // ----------------------------------------
  // input path
  // ----------------------------------------
  // first stage feeds only the second to keep metastability contained
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= line_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire level_now = sync2_reg ^ ctrl_reg[`DIOCA_CTRL_INVERT];
  wire rise = level_now && !level_reg;
  wire fall = !level_now && level_reg;
  wire in_en = !out_mode;

  always_ff @(posedge clk) begin
    if (rst)
      level_reg <= 1'b0;
    else
      level_reg <= level_now;
  end

  // latch holds until software reads status or selects no latch; a new edge wins over clear
  wire latch_ev = in_en &&
    ((latch_sel == DIOCA_LATCH_RISE && rise) ||
     (latch_sel == DIOCA_LATCH_FALL && fall));
  wire status_rd = rd_acc && ack_reg && avs_address == `DIOCA_OFS_STATUS;
  always_ff @(posedge clk) begin
    if (rst)
      latched_reg <= 1'b0;
    else if (latch_ev)
      latched_reg <= 1'b1;
    else if ((status_rd && avs_readdata[1]) ||
             latch_sel == DIOCA_LATCH_NONE)
      latched_reg <= 1'b0;
  end

  // ----------------------------------------
  // alarm state machine
  // ----------------------------------------
  wire trig_cond =
    (trig_sel == DIOCA_TRIG_INACTIVE && fall) ||
    (trig_sel == DIOCA_TRIG_ACTIVE && rise);
  wire quiet =
    (trig_sel == DIOCA_TRIG_INACTIVE && level_now) ||
    (trig_sel == DIOCA_TRIG_ACTIVE && !level_now);
  logic al_set;
  logic al_clr;
  always_comb begin
    al_set = 1'b0;
    al_clr = 1'b0;
    case (alarm_reg)
      DIOCA_AL_CLEAR:
        al_set = in_en && trig_cond;
      DIOCA_AL_RAISED:
        if (ctrl_reg[`DIOCA_CTRL_MANUAL])
          al_clr = cmd_clear;
        else
          al_clr = quiet || trig_sel == DIOCA_TRIG_OFF;
      default: al_clr = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst)
      alarm_reg <= DIOCA_AL_CLEAR;
    else if (al_set)
      alarm_reg <= DIOCA_AL_RAISED;
    else if (al_clr)
      alarm_reg <= DIOCA_AL_CLEAR;
  end

  // one-cycle notification on every change, severity always critical
  always_ff @(posedge clk) begin
    if (rst) begin
      event_valid <= 1'b0;
      event_alarm_set <= 1'b0;
      event_email <= 1'b0;
      event_log <= 1'b0;
      event_trap <= 1'b0;
      event_severity <= 3'h0;
      event_value <= 1'b0;
    end else begin
      event_valid <= al_set || al_clr;
      event_alarm_set <= al_set;
      event_email <= (al_set || al_clr) &&
        ctrl_reg[`DIOCA_CTRL_EMAIL];
      event_log <= (al_set || al_clr) &&
        ctrl_reg[`DIOCA_CTRL_LOG];
      event_trap <= (al_set || al_clr) &&
        ctrl_reg[`DIOCA_CTRL_TRAP];
      event_severity <= `DIOCA_SEV_CRITICAL;
      event_value <= level_now;
    end
  end

  // ----------------------------------------
  // output sequencer
  // ----------------------------------------
  wire tick = tick_reg == STEP_CYC - 1;
  always_ff @(posedge clk) begin
    if (rst || ost_reg == DIOCA_ST_IDLE || tick)
      tick_reg <= 32'h0000_0000;
    else
      tick_reg <= tick_reg + 32'h0000_0001;
  end
  wire unit_done = tick && units_reg == `DIOCA_UNITS_MIN;

  always_ff @(posedge clk) begin
    if (rst) begin
      ost_reg <= DIOCA_ST_IDLE;
      out_active_reg <= 1'b0;
      units_reg <= `DIOCA_UNITS_RESET;
      pulses_reg <= `DIOCA_UNITS_RESET;
    end else if (!out_mode) begin
      ost_reg <= DIOCA_ST_IDLE;
      out_active_reg <= 1'b0;
    end else if (fs_hit && fs_sel != DIOCA_FS_NONE) begin
      ost_reg <= DIOCA_ST_IDLE;
      out_active_reg <= fs_sel == DIOCA_FS_ON;
    end else if (cmd_off) begin
      ost_reg <= DIOCA_ST_IDLE;
      out_active_reg <= 1'b0;
    end else if (cmd_on) begin
      case (om_sel)
        DIOCA_OM_PULSE: begin
          ost_reg <= DIOCA_ST_PON;
          out_active_reg <= 1'b1;
          units_reg <= actw_reg;
          pulses_reg <= pcount_reg;
        end
        DIOCA_OM_DLY_ON: begin
          ost_reg <= DIOCA_ST_WAIT;
          out_active_reg <= 1'b0;
          units_reg <= delay_reg;
        end
        DIOCA_OM_DLY_OFF: begin
          ost_reg <= DIOCA_ST_WAIT;
          out_active_reg <= 1'b1;
          units_reg <= delay_reg;
        end
        default: begin
          ost_reg <= DIOCA_ST_IDLE;
          out_active_reg <= 1'b1;
        end
      endcase
    end else begin
      if (tick && !unit_done)
        units_reg <= units_reg - 14'h0001;
      case (ost_reg)
        DIOCA_ST_WAIT:
          if (unit_done) begin
            ost_reg <= DIOCA_ST_IDLE;
            out_active_reg <= !out_active_reg;
          end
        DIOCA_ST_PON:
          if (unit_done) begin
            ost_reg <= DIOCA_ST_POFF;
            out_active_reg <= 1'b0;
            units_reg <= inactw_reg;
          end
        DIOCA_ST_POFF:
          if (unit_done) begin
            if (outcfg_reg[`DIOCA_OUT_COUNTED] &&
                pulses_reg == `DIOCA_UNITS_MIN) begin
              ost_reg <= DIOCA_ST_IDLE;
            end else begin
              ost_reg <= DIOCA_ST_PON;
              out_active_reg <= 1'b1;
              units_reg <= actw_reg;
              if (outcfg_reg[`DIOCA_OUT_COUNTED])
                pulses_reg <= pulses_reg - 14'h0001;
            end
          end
        default: ost_reg <= DIOCA_ST_IDLE;
      endcase
    end
  end
  wire seq_done = out_mode && ost_reg != DIOCA_ST_IDLE &&
    ost_reg != DIOCA_ST_WAIT && unit_done &&
    ost_reg == DIOCA_ST_POFF && outcfg_reg[`DIOCA_OUT_COUNTED] &&
    pulses_reg == `DIOCA_UNITS_MIN && !cmd_wr && !fs_hit;

  // drive style decoded from the active level, both low while in input
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_high <= 1'b0;
      drive_low <= 1'b0;
    end else begin
      drive_high <= out_mode && out_active_reg &&
        drv_sel != DIOCA_DRV_SINK;
      drive_low <= out_mode &&
        ((drv_sel == DIOCA_DRV_SINK && out_active_reg) ||
         (drv_sel == DIOCA_DRV_BOTH && !out_active_reg));
    end
  end

  // ----------------------------------------
  // interrupts: sticky, cleared by reading, set wins
  // ----------------------------------------
  wire [3:0] irq_ev = {seq_done, latch_ev, al_clr, al_set};
  wire stat_rd = rd_acc && ack_reg && avs_address == `DIOCA_OFS_IRQ_STAT;
  always_ff @(posedge clk) begin
    if (rst)
      irq_stat_reg <= 4'h0;
    // clear only what the read showed, so a wait-cycle event survives
    else if (stat_rd)
      irq_stat_reg <= irq_ev | (irq_stat_reg & ~avs_readdata[3:0]);
    else
      irq_stat_reg <= irq_ev | irq_stat_reg;
  end
  always_ff @(posedge clk) begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |((irq_ev | irq_stat_reg) & irq_mask_reg);
  end

  // ----------------------------------------
  // read data, registered with the ack
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_reg) begin
      case (avs_address)
        `DIOCA_OFS_CTRL: avs_readdata <= {22'h0, ctrl_reg};
        `DIOCA_OFS_OUTCFG: avs_readdata <= {25'h0, outcfg_reg};
        `DIOCA_OFS_ACTW: avs_readdata <= {18'h0, actw_reg};
        `DIOCA_OFS_INACTW: avs_readdata <= {18'h0, inactw_reg};
        `DIOCA_OFS_DELAY: avs_readdata <= {18'h0, delay_reg};
        `DIOCA_OFS_PCOUNT: avs_readdata <= {18'h0, pcount_reg};
        `DIOCA_OFS_STATUS: avs_readdata <= {25'h0, ost_reg,
          out_active_reg, alarm_reg, latched_reg, level_now};
        `DIOCA_OFS_IRQ_STAT: avs_readdata <= {28'h0, irq_stat_reg};
        `DIOCA_OFS_IRQ_MASK: avs_readdata <= {28'h0, irq_mask_reg};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : dioca_channel

// >>> core/dioca_params.svh
`ifndef DIOCA_PARAMS_SVH
`define DIOCA_PARAMS_SVH
// How it works
// - input mode default; status shows line level
// - latch none, rising or falling; remembered
// - invert reports opposite of line level
// - trigger disabled never raises an alarm
// - trigger inactive: alarm on going inactive
// - trigger active: alarm on going active
// - auto clear when input leaves trigger state
// - manual clear holds alarm until software clears
// - email event on trigger and clear
// - log event on trigger and clear
// - trap event on trigger and clear
// - output drive sink, source or both
// - pulse train continuous or counted after activation
// - delayed activation or deactivation after start
// - failsafe expiry activates or deactivates output
// - steps of 100 ms, 1 to 9999

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DIOCA_OFS_CTRL 8'h00
`define DIOCA_OFS_OUTCFG 8'h04
`define DIOCA_OFS_ACTW 8'h08
`define DIOCA_OFS_INACTW 8'h0C
`define DIOCA_OFS_DELAY 8'h10
`define DIOCA_OFS_PCOUNT 8'h14
`define DIOCA_OFS_CMD 8'h18
`define DIOCA_OFS_STATUS 8'h1C
`define DIOCA_OFS_IRQ_STAT 8'h20
`define DIOCA_OFS_IRQ_MASK 8'h24
`define DIOCA_OFS_EVENT 8'h28

// ----------------------------------------
// ctrl fields and reset
// ----------------------------------------
`define DIOCA_CTRL_OUTMODE 0
`define DIOCA_CTRL_INVERT 1
`define DIOCA_CTRL_LATCH_LO 2
`define DIOCA_CTRL_TRIG_LO 4
`define DIOCA_CTRL_MANUAL 6
`define DIOCA_CTRL_EMAIL 7
`define DIOCA_CTRL_LOG 8
`define DIOCA_CTRL_TRAP 9
`define DIOCA_CTRL_RESET 10'h000

// ----------------------------------------
// output config: type[1:0] mode[3:2] count[4] fs[6:5]
// ----------------------------------------
`define DIOCA_OUT_TYPE_LO 0
`define DIOCA_OUT_MODE_LO 2
`define DIOCA_OUT_COUNTED 4
`define DIOCA_OUT_FS_LO 5
`define DIOCA_OUTCFG_RESET 7'h00

// ----------------------------------------
// command bits and irq bits
// ----------------------------------------
`define DIOCA_CMD_ON 0
`define DIOCA_CMD_OFF 1
`define DIOCA_CMD_CLEAR 2
`define DIOCA_CMD_FAILSAFE 3
`define DIOCA_IRQ_TRIG 0
`define DIOCA_IRQ_CLR 1
`define DIOCA_IRQ_LATCH 2
`define DIOCA_IRQ_DONE 3

// ----------------------------------------
// timing
// ----------------------------------------
`define DIOCA_CLK_MHZ 250
`define DIOCA_STEP_MS 100
`define DIOCA_STEP_CYC (`DIOCA_STEP_MS * 1000 * `DIOCA_CLK_MHZ)
`define DIOCA_UNITS_MIN 14'h0001
`define DIOCA_UNITS_MAX 14'h270F
`define DIOCA_UNITS_RESET 14'h0001
`define DIOCA_SEV_CRITICAL 3'h2
`endif

// >>> core/dioca_pkg.sv
package dioca_pkg;
  typedef enum logic [1:0] {
    DIOCA_LATCH_NONE = 2'b00,
    DIOCA_LATCH_RISE = 2'b01,
    DIOCA_LATCH_FALL = 2'b10
  } dioca_latch_t;
  typedef enum logic [1:0] {
    DIOCA_TRIG_OFF = 2'b00,
    DIOCA_TRIG_INACTIVE = 2'b01,
    DIOCA_TRIG_ACTIVE = 2'b10
  } dioca_trig_t;
  typedef enum logic [1:0] {
    DIOCA_DRV_SINK = 2'b00,
    DIOCA_DRV_SOURCE = 2'b01,
    DIOCA_DRV_BOTH = 2'b10
  } dioca_drv_t;
  typedef enum logic [1:0] {
    DIOCA_OM_MANUAL = 2'b00,
    DIOCA_OM_PULSE = 2'b01,
    DIOCA_OM_DLY_ON = 2'b10,
    DIOCA_OM_DLY_OFF = 2'b11
  } dioca_omode_t;
  typedef enum logic [1:0] {
    DIOCA_FS_NONE = 2'b00,
    DIOCA_FS_ON = 2'b01,
    DIOCA_FS_OFF = 2'b10
  } dioca_fs_t;
  typedef enum logic [2:0] {
    DIOCA_ST_IDLE = 3'b000,
    DIOCA_ST_WAIT = 3'b001,
    DIOCA_ST_PON = 3'b010,
    DIOCA_ST_POFF = 3'b011
  } dioca_ost_t;
  typedef enum logic [0:0] {
    DIOCA_AL_CLEAR = 1'b0,
    DIOCA_AL_RAISED = 1'b1
  } dioca_alarm_t;
endpackage : dioca_pkg

// >>> verification/dioca_field_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// field wiring: sensor contact and actuator load
// ----------------------------------------
module dioca_field_model (
  input wire logic sense_level,
  input wire logic drive_high,
  input wire logic drive_low,
  output logic line_in,
  output logic load_on
);
  // contact level reaches the pin unsynchronised, like a real sensor
  assign line_in = sense_level;
  // the load draws current whenever the channel sources or sinks
  assign load_on = drive_high | drive_low;
endmodule : dioca_field_model

// >>> verification/dioca_channel_properties.sv
`timescale 1ns/1ps
`include "dioca_params.svh"
// ----------------------------------------
// bus, reset, event and drive properties
// ----------------------------------------
module dioca_channel_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic drive_high,
  input wire logic drive_low,
  input wire logic event_valid,
  input wire logic event_alarm_set,
  input wire logic event_email,
  input wire logic event_log,
  input wire logic event_trap,
  input wire logic [2:0] event_severity
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // first edge out of reset must show the quiet state
  property p_rst_quiet;
    $fell(rst) |-> avs_waitrequest && !irq && !drive_high && !drive_low;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not quiet after reset");
  // every request is answered after exactly one wait cycle
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack)
    else $error("request not acknowledged in one cycle");
  property p_ack_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("acknowledge longer than one cycle");
  property p_no_spurious;
    avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("acknowledge without a request");
  // holes in the map read as zero
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > 8'h28
      |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_sev;
    event_valid |-> event_severity == `DIOCA_SEV_CRITICAL;
  endproperty
  a_sev: assert property (p_sev)
    else $error("event severity not critical");
  // notices only ride on a real alarm change
  property p_email;
    event_email |-> event_valid;
  endproperty
  a_email: assert property (p_email)
    else $error("email notice without event");
  property p_log;
    event_log |-> event_valid;
  endproperty
  a_log: assert property (p_log)
    else $error("log notice without event");
  property p_trap;
    event_trap |-> event_valid;
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap notice without event");
  // sourcing and grounding together would short the line
  property p_drv_excl;
    !(drive_high && drive_low);
  endproperty
  a_drv_excl: assert property (p_drv_excl)
    else $error("drive high and low together");
  c_write: cover property (avs_write && !avs_waitrequest);
  c_raise: cover property (event_valid && event_alarm_set);
  c_clear: cover property (event_valid && !event_alarm_set);
  c_drive: cover property (drive_high);
endmodule : dioca_channel_properties

bind dioca_channel dioca_channel_properties dioca_channel_properties_i (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .drive_high(drive_high),
  .drive_low(drive_low), .event_valid(event_valid),
  .event_alarm_set(event_alarm_set), .event_email(event_email),
  .event_log(event_log), .event_trap(event_trap),
  .event_severity(event_severity)
);

// >>> verification/dioca_channel_tb_top.sv
`timescale 1ns/1ps
`include "dioca_params.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  errors++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module dioca_channel_tb_top;
  logic clk = 1'b0;
  logic rst, avs_read, avs_write, sense, fs_exp, dh_q;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_v;
  logic avs_waitrequest, irq, line_in, drive_high, drive_low, load_on;
  logic event_valid, event_alarm_set, event_email, event_log, event_trap;
  logic event_value, ev_set, ev_val;
  logic [2:0] event_severity, ev_fl;
  logic [1:0] ex2;
  int errors, check_count, ev_n, hi_n, hr_n, e0, h0, r0;
  dioca_channel #(.STEP_CYC(10)) dioca_channel_i (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .line_in(line_in),
    .failsafe_expired(fs_exp), .drive_high(drive_high),
    .drive_low(drive_low), .event_valid(event_valid),
    .event_alarm_set(event_alarm_set), .event_email(event_email),
    .event_log(event_log), .event_trap(event_trap),
    .event_severity(event_severity), .event_value(event_value));
  dioca_field_model dioca_field_model_i (.sense_level(sense),
    .drive_high(drive_high), .drive_low(drive_low), .line_in(line_in),
    .load_on(load_on));
  always #2 clk = ~clk;
  // tallies only grow; the first alarm checks read only the low bits of ev_n, later tests compare deltas
  always @(posedge clk) begin
    if (event_valid === 1'b1) begin
      ev_n <= ev_n + 1;
      ev_set <= event_alarm_set;
      ev_val <= event_value;
      ev_fl <= {event_email, event_log, event_trap};
    end
    hi_n <= hi_n + ((drive_high === 1'b1) ? 1 : 0);
    hr_n <= hr_n + ((drive_high === 1'b1 && dh_q !== 1'b1) ? 1 : 0);
    dh_q <= drive_high;
  end
  // ----------------------------------------
  // bus and helper tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex,
                     input string nm);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd_v)
  endtask : rdc
  // line needs sync, level and event edges before it shows
  task automatic setl(input logic v);
    sense <= v;
    repeat (8) @(posedge clk);
  endtask : setl
  task automatic fsp();
    @(posedge clk);
    fs_exp <= 1'b1;
    @(posedge clk);
    fs_exp <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : fsp
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    sense = 1'b0;
    fs_exp = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(`DIOCA_OFS_CTRL, 32'h0000_0000, "ctrl");
    rdc(`DIOCA_OFS_OUTCFG, 32'h0000_0000, "outcfg");
    rdc(`DIOCA_OFS_ACTW, 32'h0000_0001, "actw");
    rdc(8'h40, 32'h0000_0000, "hole");
    setl(1'b1);
    rdc(`DIOCA_OFS_STATUS, 32'h0000_0001, "level");
    bus(1'b1, `DIOCA_OFS_CTRL, 32'h0000_0002);
    setl(1'b0);
    rdc(`DIOCA_OFS_STATUS, 32'h0000_0001, "inverted");
    // rising then falling latch, each cleared by its read
    bus(1'b1, `DIOCA_OFS_CTRL, 32'h0000_0004);
    setl(1'b1);
    rdc(`DIOCA_OFS_STATUS, 32'h0000_0003, "latch rise");
    rdc(`DIOCA_OFS_STATUS, 32'h0000_0001, "latch gone");
    bus(1'b1, `DIOCA_OFS_CTRL, 32'h0000_0008);
    setl(1'b0);
    rdc(`DIOCA_OFS_STATUS, 32'h0000_0002, "latch fall");
    `CHK("no alarm", 0, ev_n)
    // trigger on active, auto clear, every notice, irq unmasked
    bus(1'b1, `DIOCA_OFS_IRQ_MASK, 32'h0000_0003);
    bus(1'b0, `DIOCA_OFS_IRQ_STAT, 32'h0000_0000);
    bus(1'b1, `DIOCA_OFS_CTRL, 32'h0000_03A0);
    setl(1'b1);
    `CHK("raise", 6'h3F, {ev_n[0], ev_set, ev_val, ev_fl})
    `CHK("irq", 1'b1, irq)
    rdc(`DIOCA_OFS_STATUS, 32'h0000_0005, "alarm");
    setl(1'b0);
    `CHK("clear", 7'h47, {ev_n[1:0], ev_set, ev_val, ev_fl})
    rdc(`DIOCA_OFS_IRQ_STAT, 32'h0000_0003, "irq stat");
    repeat (2) @(posedge clk);
    `CHK("irq off", 1'b0, irq)
    // trigger on inactive, manual clear, notices off; set while line low
    bus(1'b1, `DIOCA_OFS_CTRL, 32'h0000_0050);
    setl(1'b1);
    e0 = ev_n;
    setl(1'b0);
    `CHK("raise2", 5'h18, {ev_n - e0 == 1, ev_set, ev_fl})
    setl(1'b1);
    rdc(`DIOCA_OFS_STATUS, 32'h0000_0005, "held");
    bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0004);
    repeat (4) @(posedge clk);
    `CHK("manual", 2'b10, {ev_n - e0 == 2, ev_set})
    // drive styles: sink, source, both
    bus(1'b1, `DIOCA_OFS_CTRL, 32'h0000_0001);
    for (int t = 0; t < 3; t++) begin
      bus(1'b1, `DIOCA_OFS_OUTCFG, 32'(t));
      bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0001);
      repeat (4) @(posedge clk);
      ex2 = (t == 0) ? 2'b01 : 2'b10;
      `CHK("on", ex2, {drive_high, drive_low})
      `CHK("load", 1'b1, load_on)
      bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0002);
      repeat (4) @(posedge clk);
      ex2 = (t == 2) ? 2'b01 : 2'b00;
      `CHK("off", ex2, {drive_high, drive_low})
    end
    // two counted pulses, 2 units on and 1 unit off
    bus(1'b1, `DIOCA_OFS_ACTW, 32'h0000_0002);
    bus(1'b1, `DIOCA_OFS_INACTW, 32'h0000_0001);
    bus(1'b1, `DIOCA_OFS_PCOUNT, 32'h0000_0002);
    bus(1'b1, `DIOCA_OFS_OUTCFG, 32'h0000_0015);
    bus(1'b0, `DIOCA_OFS_IRQ_STAT, 32'h0000_0000);
    h0 = hi_n;
    r0 = hr_n;
    bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0001);
    repeat (100) @(posedge clk);
    `CHK("high cycles", 40, hi_n - h0)
    `CHK("pulses", 2, hr_n - r0)
    rdc(`DIOCA_OFS_IRQ_STAT, 32'h0000_0008, "done");
    // endless pulses: 30-cycle period gives four rises in 100 cycles
    bus(1'b1, `DIOCA_OFS_OUTCFG, 32'h0000_0005);
    r0 = hr_n;
    bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0001);
    repeat (100) @(posedge clk);
    `CHK("endless", 4, hr_n - r0)
    bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0002);
    // delay of 3 units before going on, then before going off
    bus(1'b1, `DIOCA_OFS_DELAY, 32'h0000_0003);
    for (int m = 2; m < 4; m++) begin
      bus(1'b1, `DIOCA_OFS_OUTCFG, 32'h0000_0001 | 32'(m << 2));
      bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0001);
      repeat (15) @(posedge clk);
      `CHK("early", m == 3, drive_high)
      repeat (30) @(posedge clk);
      `CHK("late", m == 2, drive_high)
      bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0002);
    end
    // failsafe: activate, then deactivate, then by software command
    bus(1'b1, `DIOCA_OFS_OUTCFG, 32'h0000_0021);
    fsp();
    `CHK("fs on", 1'b1, drive_high)
    bus(1'b1, `DIOCA_OFS_OUTCFG, 32'h0000_0041);
    fsp();
    `CHK("fs off", 1'b0, drive_high)
    bus(1'b1, `DIOCA_OFS_OUTCFG, 32'h0000_0021);
    bus(1'b1, `DIOCA_OFS_CMD, 32'h0000_0008);
    repeat (2) @(posedge clk);
    `CHK("fs soft", 1'b1, drive_high)
    bus(1'b1, `DIOCA_OFS_ACTW, 32'h0000_0000);
    rdc(`DIOCA_OFS_ACTW, 32'h0000_0001, "clamp lo");
    bus(1'b1, `DIOCA_OFS_ACTW, 32'h0000_FFFF);
    rdc(`DIOCA_OFS_ACTW, 32'h0000_270F, "clamp hi");
    complete_run();
  end
endmodule : dioca_channel_tb_top
